// file: hw/pdsm_mapper.sv
// Program page, data window and data space decode with return stack.
// Assumes the core drives fetch, data and stack strobes on clk and
// that the protection option arrives asynchronously from a fuse.
`timescale 1ns/1ps
module pdsm_mapper (
  input  wire logic                          clk,         // 10 MHz clock
  input  wire logic                          rst,         // Sync reset, high
  input  wire logic                          clkEn,       // Freezes state when low
  input  wire logic                          fetchReq,    // Program fetch strobe
  input  wire logic [pdsm_pkg::PC_W-1:0]     progCounter, // Program counter
  input  wire pdsm_pkg::pdsm_dbus_t          dbus,        // Data space access
  input  wire logic                          stackPush,   // Call/interrupt entry
  input  wire logic                          stackPop,    // Return
  input  wire logic [pdsm_pkg::PC_W-1:0]     pushAddr,    // Return address
  input  wire logic                          protectOpt,  // Readout option, async
  output logic [pdsm_pkg::PROG_AW-1:0]       fetchAddr,   // Physical fetch address
  output logic                               fetchValid,  // Fetch address valid
  output logic [pdsm_pkg::PROG_AW-1:0]       winAddr,     // Window read address
  output logic                               winValid,    // Window read valid
  output pdsm_pkg::pdsm_region_t             region,      // Decoded selects
  output logic [pdsm_pkg::PC_W-1:0]          popAddr,     // Popped return address
  output logic                               extReadOk    // External readout allowed
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [pdsm_pkg::PAGE_W-1:0]  pageSel;   // Program page register
    logic [pdsm_pkg::WBASE_W-1:0] winBase;   // Window base register
    logic [7:0]                   bankSel;   // Bank select register
    logic [pdsm_pkg::PROG_AW-1:0] fetchAddr; // Fetch address out
    logic                         fetchVal;  // Fetch valid out
    logic [pdsm_pkg::PROG_AW-1:0] winAddr;   // Window address out
    logic                         winVal;    // Window valid out
    pdsm_pkg::pdsm_region_t       region;    // Region selects out
    logic                         protS1;    // Protection sync stage 1
    logic                         protS2;    // Protection sync stage 2
    logic                         extOk;     // Readout allowed out
    logic [2:0]                   sp;        // Next free stack slot
    logic [2:0]                   depth;     // Filled entries
  } pdsm_state_t;

  pdsm_state_t st_r;   // Registered state
  pdsm_state_t st_nxt; // Next state

  logic       memWr;   // Stack write
  logic       memRd;   // Stack read
  logic [2:0] rdSlot;  // Top entry slot

  // ==========================================================
  // Helpers
  // Write strobe aimed at one mapping register
  function automatic logic regWrite(input pdsm_pkg::pdsm_dbus_t b,
                                    input logic [7:0] target);
    regWrite = b.wr && (b.addr == target);
  endfunction

  // Decode a data address into region selects
  function automatic pdsm_pkg::pdsm_region_t decode(input logic [7:0] a,
                                                    input logic [7:0] bank);
    pdsm_pkg::pdsm_region_t r;
    r = '0;
    if (a <= pdsm_pkg::BANK_HI) begin
      r.eeBank  = {bank[pdsm_pkg::BANK_EE1], bank[pdsm_pkg::BANK_EE0]};
      r.ramBank = {bank[pdsm_pkg::BANK_RAM2], bank[pdsm_pkg::BANK_RAM1]};
      r.lcdBank = {bank[pdsm_pkg::BANK_LCD2], bank[pdsm_pkg::BANK_LCD1]};
    end else if (a <= pdsm_pkg::WIN_HI) begin
      r.window = 1'b1;
    end else if (a <= pdsm_pkg::CORE_HI) begin
      r.coreReg = 1'b1;
    end else if (a <= pdsm_pkg::GPRAM_HI) begin
      r.gpRam = 1'b1;
    end else if (a == pdsm_pkg::ACCUM_ADDR) begin
      r.accum = 1'b1;
    end else begin
      r.periph = 1'b1;
    end
    decode = r;
  endfunction

  // Wrap a stack slot index
  function automatic logic [2:0] slotDec(input logic [2:0] s);
    slotDec = (s == 3'h0) ? 3'(pdsm_pkg::STACK_DEPTH - 1) : s - 3'h1;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    memWr  = 1'b0;
    memRd  = 1'b0;
    rdSlot = slotDec(st_r.sp);
    // Mapping registers change only on a data write, never on calls
    if (regWrite(dbus, pdsm_pkg::ADDR_PAGE_SEL)) begin
      st_nxt.pageSel = dbus.wdata[pdsm_pkg::PAGE_W-1:0];
    end
    if (regWrite(dbus, pdsm_pkg::ADDR_WINDOW_BASE)) begin
      st_nxt.winBase = dbus.wdata[pdsm_pkg::WBASE_W-1:0];
    end
    if (regWrite(dbus, pdsm_pkg::ADDR_BANK_SEL)) begin
      st_nxt.bankSel = dbus.wdata;
    end
    // Program fetch address, page from current register value
    st_nxt.fetchVal = fetchReq;
    if (fetchReq) begin
      if (progCounter[pdsm_pkg::PC_PAGE_B]) begin
        st_nxt.fetchAddr = {pdsm_pkg::STATIC_PAGE, progCounter[10:0]};
      end else begin
        st_nxt.fetchAddr = {st_r.pageSel, progCounter[10:0]};
      end
    end
    // Window read address and region decode
    st_nxt.winVal = dbus.rd && (dbus.addr >= pdsm_pkg::WIN_LO)
                    && (dbus.addr <= pdsm_pkg::WIN_HI);
    if (st_nxt.winVal) begin
      st_nxt.winAddr = {st_r.winBase, dbus.addr[pdsm_pkg::WIN_LSB-1:0]};
    end
    st_nxt.region = (dbus.rd || dbus.wr) ? decode(dbus.addr, st_r.bankSel)
                                         : '0;
    // Protection option synchroniser and readout gate
    st_nxt.protS1 = protectOpt;
    st_nxt.protS2 = st_r.protS1;
    st_nxt.extOk  = !st_r.protS2;
    // Return stack, circular, oldest entry overwritten when full
    if (stackPush) begin
      memWr      = 1'b1;
      st_nxt.sp  = (st_r.sp == 3'(pdsm_pkg::STACK_DEPTH - 1)) ? 3'h0
                                                             : st_r.sp + 3'h1;
      if (st_r.depth != 3'(pdsm_pkg::STACK_DEPTH)) begin
        st_nxt.depth = st_r.depth + 3'h1;
      end
    end else if (stackPop && (st_r.depth != 3'h0)) begin
      memRd        = 1'b1;
      st_nxt.sp    = rdSlot;
      st_nxt.depth = st_r.depth - 3'h1;
    end
  end

  // ==========================================================
  // State register; mapping registers survive reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.fetchAddr <= '0;
      st_r.fetchVal  <= 1'b0;
      st_r.winAddr   <= '0;
      st_r.winVal    <= 1'b0;
      st_r.region    <= '0;
      st_r.protS1    <= 1'b1;
      st_r.protS2    <= 1'b1;
      st_r.extOk     <= 1'b0;
      st_r.sp        <= 3'h0;
      st_r.depth     <= 3'h0;
      st_r.pageSel   <= st_r.pageSel;
      st_r.winBase   <= st_r.winBase;
      st_r.bankSel   <= st_r.bankSel;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Return stack storage
  pdsm_stack_mem #(
    .WIDTH (pdsm_pkg::PC_W),
    .DEPTH (pdsm_pkg::STACK_DEPTH),
    .AW    (3)
  ) u_stack (
    .clk    (clk),
    .clkEn  (clkEn),
    .wrEn   (memWr),
    .wrAddr (st_r.sp),
    .wrData (pushAddr),
    .rdEn   (memRd),
    .rdAddr (rdSlot),
    .rdData (popAddr)
  );

  // Outputs from state flops
  assign fetchAddr  = st_r.fetchAddr;
  assign fetchValid = st_r.fetchVal;
  assign winAddr    = st_r.winAddr;
  assign winValid   = st_r.winVal;
  assign region     = st_r.region;
  assign extReadOk  = st_r.extOk;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !clkEn);

  property p_static_page;
    fetchReq && progCounter[11] ##1 clkEn |-> fetchAddr[12:11] == 2'h1;
  endproperty
  a_static_page: assert property (p_static_page) else $error("static page miss");

  property p_dyn_page;
    fetchReq && !progCounter[11] ##1 clkEn
      |-> fetchAddr == {$past(st_r.pageSel, 1), $past(progCounter[10:0], 1)};
  endproperty
  a_dyn_page: assert property (p_dyn_page) else $error("dynamic page wrong");

  property p_page_write;
    dbus.wr && dbus.addr == 8'hca && !rst ##1 clkEn && fetchReq && !progCounter[11]
      ##1 clkEn |-> fetchAddr[12:11] == $past(dbus.wdata[1:0], 2);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_page_hold;
    $changed(st_r.pageSel) |-> $past(dbus.wr) && $past(dbus.addr) == 8'hca;
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed");

  property p_window;
    dbus.rd && dbus.addr[7:6] == 2'h1 && !(dbus.wr) ##1 clkEn
      |-> winValid && winAddr == {$past(st_r.winBase, 1), $past(dbus.addr[5:0], 1)};
  endproperty
  a_window: assert property (p_window) else $error("window address wrong");

  property p_wbase;
    dbus.wr && dbus.addr == 8'hc9 ##1 clkEn && dbus.rd && dbus.addr[7:6] == 2'h1
      ##1 clkEn |-> winAddr[12:6] == $past(dbus.wdata[6:0], 2);
  endproperty
  a_wbase: assert property (p_wbase) else $error("window base lost");

  property p_protect;
    protectOpt [*3] ##1 clkEn |-> !extReadOk;
  endproperty
  a_protect: assert property (p_protect) else $error("readout not blocked");

  property p_gpram;
    dbus.rd && dbus.addr >= 8'h84 && dbus.addr <= 8'hbf ##1 clkEn
      |-> region.gpRam && !region.coreReg && !region.accum;
  endproperty
  a_gpram: assert property (p_gpram) else $error("RAM decode wrong");

  property p_accum;
    dbus.rd && dbus.addr == 8'hff ##1 clkEn |-> region.accum && !region.periph;
  endproperty
  a_accum: assert property (p_accum) else $error("accumulator decode wrong");

  property p_bank;
    dbus.rd && dbus.addr <= 8'h3f && st_r.bankSel == 8'h08 ##1 clkEn
      |-> region.ramBank == 2'h1 && region.eeBank == 2'h0;
  endproperty
  a_bank: assert property (p_bank) else $error("bank decode wrong");

  property p_depth;
    st_r.depth <= 3'h6;
  endproperty
  a_depth: assert property (p_depth) else $error("stack depth over six");

  c_window: cover property (winValid);
  c_static: cover property (fetchValid && fetchAddr[12:11] == 2'h1);
  c_full:   cover property (st_r.depth == 3'h6);
  c_pop:    cover property (stackPop && st_r.depth != 3'h0);

endmodule

// file: hw/pdsm_pkg.sv
// Constants and carrier types of the program/data space mapper.
// Assumes one 10 MHz clock, a synchronous active-high reset and a core
// that presents program and data addresses in the same clock domain.
// Operation
// - Write-only page register picks low 2K page
// - Counter bit 11 set always fetches page 1
// - Page codes 0..3 map to pages 0..3
// - Page register keeps its content through reset
// - Readout protection option blocks external program reads
// - Data reads 40h..7Fh return program bytes
// - Window address is base above six address bits
// - Window base: write-only, seven bits, bit 7 unused
// - Window moves in 64-byte steps over 8K
// - Banked 64-byte pages appear at 00h..3Fh
// - Two RAM, two EEPROM, two LCD banks
// - Six-entry, 12-bit hardware return stack
// - Core registers 80h..83h, RAM to BFh, accumulator FFh
// - Sixty bytes of directly addressed RAM
// - Calls and interrupts leave page register alone
package pdsm_pkg;

  // ==========================================================
  // Data space addresses
  localparam logic [7:0] ADDR_WINDOW_BASE = 8'hc9; // Window base register
  localparam logic [7:0] ADDR_PAGE_SEL    = 8'hca; // Program page register
  localparam logic [7:0] ADDR_BANK_SEL    = 8'hcb; // Bank select register
  localparam logic [7:0] BANK_HI          = 8'h3f; // Top of banked region
  localparam logic [7:0] WIN_LO           = 8'h40; // Window start
  localparam logic [7:0] WIN_HI           = 8'h7f; // Window end
  localparam logic [7:0] CORE_LO          = 8'h80; // Index/short-direct regs
  localparam logic [7:0] CORE_HI          = 8'h83; // Last core register
  localparam logic [7:0] GPRAM_LO         = 8'h84; // General RAM start
  localparam logic [7:0] GPRAM_HI         = 8'hbf; // General RAM end
  localparam logic [7:0] PERIPH_LO        = 8'hc0; // Peripheral region start
  localparam logic [7:0] ACCUM_ADDR       = 8'hff; // Accumulator

  // ==========================================================
  // Widths and field positions
  localparam int PC_W      = 12;                   // Program counter width
  localparam int PROG_AW   = 13;                   // 8K program memory
  localparam int WIN_LSB   = 6;                    // Window offset bits
  localparam int WBASE_W   = 7;                    // Window base bits
  localparam int PAGE_W    = 2;                    // Page select bits
  localparam int PC_PAGE_B = 11;                   // Static page select bit
  localparam int STACK_DEPTH = 6;                  // Return stack levels
  localparam logic [1:0] STATIC_PAGE = 2'h1;       // Always-visible page

  // Bank select bit positions
  localparam int BANK_EE0  = 0;
  localparam int BANK_EE1  = 1;
  localparam int BANK_RAM1 = 3;
  localparam int BANK_RAM2 = 4;
  localparam int BANK_LCD1 = 5;
  localparam int BANK_LCD2 = 6;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [1:0] ramBank;   // Banked RAM page 1/2 selected
    logic [1:0] eeBank;    // Banked EEPROM page 0/1 selected
    logic [1:0] lcdBank;   // Banked LCD RAM page 1/2 selected
    logic       window;    // Read-only program window
    logic       coreReg;   // Index and short-direct registers
    logic       gpRam;     // Directly addressed RAM
    logic       periph;    // Peripheral register region
    logic       accum;     // Accumulator
  } pdsm_region_t;

  typedef struct packed {
    logic [7:0] addr;      // Data space address
    logic [7:0] wdata;     // Write data
    logic       wr;        // Write strobe
    logic       rd;        // Read strobe
  } pdsm_dbus_t;

endpackage

// file: hw/pdsm_stack_mem.sv
// Small memory holding the return stack entries.
// Assumes one write and one read per cycle; read data registered.
`timescale 1ns/1ps
module pdsm_stack_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 6,
  parameter int AW    = 3
) (
  input  wire logic             clk,    // System clock
  input  wire logic             clkEn,  // Freezes memory when low
  input  wire logic             wrEn,   // Write strobe
  input  wire logic [AW-1:0]    wrAddr, // Write slot
  input  wire logic [WIDTH-1:0] wrData, // Entry to store
  input  wire logic             rdEn,   // Read strobe
  input  wire logic [AW-1:0]    rdAddr, // Read slot
  output logic      [WIDTH-1:0] rdData  // Registered read data
);

  // ==========================================================
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];  // Entries

  // Write and registered read
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      if (rdEn) begin
        rdData <= mem[rdAddr];
      end
    end
  end

endmodule

// file: tb/pdsm_core_model.sv
// Core-side partner: issues fetch, data and stack requests to the mapper.
// Assumes the mapper samples every request on the rising edge of clk.
`timescale 1ns/1ps
module pdsm_core_model (
  input  wire logic                 clk,         // System clock
  output logic                      fetchReq,    // Fetch strobe
  output logic [pdsm_pkg::PC_W-1:0] progCounter, // Program counter
  output pdsm_pkg::pdsm_dbus_t      dbus,        // Data access
  output logic                      stackPush,   // Push strobe
  output logic                      stackPop,    // Pop strobe
  output logic [pdsm_pkg::PC_W-1:0] pushAddr     // Return address
);
  localparam time DLY = 1ns; // Drive delay after the edge

  // ==========================================================
  // Idle state at time zero
  initial begin
    fetchReq = 1'b0;
    progCounter = 12'h000;
    dbus = '0;
    stackPush = 1'b0;
    stackPop = 1'b0;
    pushAddr = 12'h000;
  end

  // ==========================================================
  // Request framing
  task automatic start();
    @(posedge clk);
    #DLY;
  endtask

  // Release strobes; idle lines show inverted values, not the old ones
  task automatic finish();
    @(posedge clk);
    #DLY;
    fetchReq = 1'b0;
    stackPush = 1'b0;
    stackPop = 1'b0;
    dbus.wr = 1'b0;
    dbus.rd = 1'b0;
    dbus.addr = ~dbus.addr;
    dbus.wdata = ~dbus.wdata;
    progCounter = ~progCounter;
    pushAddr = ~pushAddr;
  endtask

  // ==========================================================
  // Whole-byte write; mapping registers are never read or bit-set
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    start();
    dbus.addr = a;
    dbus.wdata = d;
    dbus.wr = 1'b1;
    finish();
  endtask

  // Mapping write, then in the very next cycle a fetch or a data read
  task automatic write_then(input logic [7:0] a, input logic [7:0] d,
                            input logic isFetch, input logic [11:0] nxt);
    start();
    dbus.addr = a;
    dbus.wdata = d;
    dbus.wr = 1'b1;
    @(posedge clk);
    #DLY;
    dbus.wr = 1'b0;
    if (isFetch) begin
      progCounter = nxt;
      fetchReq = 1'b1;
    end else begin
      dbus.addr = nxt[7:0];
      dbus.rd = 1'b1;
    end
    finish();
  endtask

  // Data read of one byte
  task automatic read_byte(input logic [7:0] a);
    start();
    dbus.addr = a;
    dbus.rd = 1'b1;
    finish();
  endtask

  // Program fetch
  task automatic fetch(input logic [11:0] pc);
    start();
    progCounter = pc;
    fetchReq = 1'b1;
    finish();
  endtask

  // Call entry
  task automatic push(input logic [11:0] v);
    start();
    pushAddr = v;
    stackPush = 1'b1;
    finish();
  endtask

  // Return
  task automatic pop();
    start();
    stackPop = 1'b1;
    finish();
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench of the program/data space mapper.
// Assumes a 100 ns clock and the core model as the only requester.
`timescale 1ns/1ps
module tb;
  logic                  clk = 1'b0;        // System clock
  logic                  rst = 1'b1;        // Sync reset
  logic                  protectOpt = 1'b0; // Readout option
  logic                  clkEn = 1'b1;      // Clock enable
  logic                  fetchReq, stackPush, stackPop, fetchValid, winValid, extReadOk;
  logic [11:0]           progCounter, pushAddr, popAddr;
  logic [12:0]           fetchAddr, winAddr;
  pdsm_pkg::pdsm_dbus_t  dbus;              // Data access
  pdsm_pkg::pdsm_region_t region;           // Decoded selects
  int                    n_fail = 0;        // Mismatches
  int                    total_checks = 0;  // Comparisons

  // ==========================================================
  // Clock and instances
  always #50 clk = ~clk;

  pdsm_core_model core (.clk(clk), .fetchReq(fetchReq), .progCounter(progCounter),
    .dbus(dbus), .stackPush(stackPush), .stackPop(stackPop), .pushAddr(pushAddr));

  pdsm_mapper DUT (.clk(clk), .rst(rst), .clkEn(clkEn), .fetchReq(fetchReq),
    .progCounter(progCounter), .dbus(dbus), .stackPush(stackPush), .stackPop(stackPop),
    .pushAddr(pushAddr), .protectOpt(protectOpt), .fetchAddr(fetchAddr),
    .fetchValid(fetchValid), .winAddr(winAddr), .winValid(winValid), .region(region),
    .popAddr(popAddr), .extReadOk(extReadOk));

  // ==========================================================
  // Compare tasks
  task automatic check_addr(input string what, input logic [12:0] e, input logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_bit(input string what, input logic e, input logic g);
    check_addr(what, {12'h000, e}, {12'h000, g});
  endtask

  task automatic check_region(input pdsm_pkg::pdsm_region_t e);
    check_addr("region", 13'(e), 13'(region));
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_page();
    for (int p = 0; p < 4; p++) begin
      core.write_byte(pdsm_pkg::ADDR_PAGE_SEL, 8'hfc | 8'(p)); // Upper bits ignored
      core.fetch(12'h123);
      check_addr("fetchAddr", {2'(p), 11'h123}, fetchAddr);
      check_bit("fetchValid", 1'b1, fetchValid);
      core.fetch(12'h923);
      check_addr("fetchAddr", {2'h1, 11'h123}, fetchAddr);
    end
  endtask

  task automatic sc_window();
    logic [6:0] bases [3] = '{7'h00, 7'h03, 7'h7f};
    logic [7:0] offs [3] = '{8'h40, 8'h45, 8'h7f};
    for (int i = 0; i < 3; i++) begin
      core.write_byte(pdsm_pkg::ADDR_WINDOW_BASE, {1'b1, bases[i]});
      core.read_byte(offs[i]);
      check_addr("winAddr", {bases[i], offs[i][5:0]}, winAddr);
      check_bit("winValid", 1'b1, winValid);
    end
    core.read_byte(8'h80);
    check_bit("winValid", 1'b0, winValid);
  endtask

  task automatic sc_region();
    logic [7:0] banks [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};
    logic [7:0] addrs [8] = '{8'h7f, 8'h80, 8'h83, 8'h84, 8'hbf, 8'hc0, 8'hfe, 8'hff};
    logic [4:0] sel [8] = '{5'h10, 5'h08, 5'h08, 5'h04, 5'h04, 5'h02, 5'h02, 5'h01};
    pdsm_pkg::pdsm_region_t e;
    for (int i = 0; i < 6; i++) begin
      core.write_byte(pdsm_pkg::ADDR_BANK_SEL, banks[i]);
      core.read_byte(8'h3f);
      e = '0;
      e.ramBank = {banks[i][4], banks[i][3]};
      e.eeBank = {banks[i][1], banks[i][0]};
      e.lcdBank = {banks[i][6], banks[i][5]};
      check_region(e);
    end
    for (int i = 0; i < 8; i++) begin
      core.read_byte(addrs[i]);
      e = '0;
      {e.window, e.coreReg, e.gpRam, e.periph, e.accum} = sel[i];
      check_region(e);
    end
  endtask

  task automatic sc_stack();
    for (int i = 0; i < 6; i++) core.push(12'h100 + 12'(i));
    for (int i = 5; i >= 0; i--) begin
      core.pop();
      check_addr("popAddr", {1'b0, 12'h100 + 12'(i)}, {1'b0, popAddr});
    end
    core.pop(); // Empty stack: answer must hold
    check_addr("popAddr", 13'h0100, {1'b0, popAddr});
    core.fetch(12'h456);
    check_addr("fetchAddr", {2'h3, 11'h456}, fetchAddr);
  endtask

  task automatic sc_reset_hold();
    core.write_byte(pdsm_pkg::ADDR_PAGE_SEL, 8'h02);
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    check_bit("fetchValid", 1'b0, fetchValid);
    check_addr("fetchAddr", 13'h0000, fetchAddr);
    check_addr("winAddr", 13'h0000, winAddr);
    core.fetch(12'h100);
    check_addr("fetchAddr", {2'h2, 11'h100}, fetchAddr);
  endtask

  // Mapping write directly followed by the access that uses it
  task automatic sc_back_to_back();
    core.write_then(pdsm_pkg::ADDR_PAGE_SEL, 8'h02, 1'b1, 12'h234);
    check_addr("fetchAddr", {2'h2, 11'h234}, fetchAddr);
    core.write_then(pdsm_pkg::ADDR_WINDOW_BASE, 8'h15, 1'b0, 12'h05a);
    check_addr("winAddr", {7'h15, 6'h1a}, winAddr);
  endtask

  // Requests while the clock enable is low are lost
  task automatic sc_freeze();
    @(posedge clk);
    #1 clkEn = 1'b0;
    core.write_byte(pdsm_pkg::ADDR_PAGE_SEL, 8'h00);
    core.fetch(12'h777);
    check_bit("fetchValid", 1'b0, fetchValid);
    check_addr("fetchAddr", {2'h2, 11'h234}, fetchAddr);
    clkEn = 1'b1;
    core.fetch(12'h777);
    check_addr("fetchAddr", {2'h2, 11'h777}, fetchAddr);
  endtask

  task automatic sc_protect();
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      #1 protectOpt = v[0];
      repeat (3) @(posedge clk);
      #1;
      check_bit("extReadOk", ~v[0], extReadOk);
    end
  endtask

  // ==========================================================
  // Verdict and hang guard
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    sc_page();
    sc_window();
    sc_region();
    sc_stack();
    sc_reset_hold();
    sc_back_to_back();
    sc_freeze();
    sc_protect();
    report_and_stop();
  end
endmodule
